/* File: core/ctl_defs.svh */
// Constants for the trap and interrupt logic: map, fields, causes, encodings
// Notes on behaviour
// RQ1: Request lines are active high and level sensitive; pending while held high.
// RQ2: The system ties reserved lines 15:12, 10:8, 6:4 and 2:0 low.
// RQ3: Line 11 is machine external, line 7 timer, line 3 software.
// RQ4: The taken pulse is high for exactly one clock cycle per interrupt taken.
// RQ5: Index of the taken line is output; meaningful only while the pulse is high.
// RQ6: Custom lines 31:16 map onto enable and pending bits 31:16.
// RQ7: After reset every interrupt is disabled until software enables it.
// RQ8: An interrupt is taken only with global and per-line enable both set.
// RQ9: Priority: lines 31 down to 16, then 11, then 3, then 7 lowest.
// RQ10: With software clearing the source drops its line after handler completion.
// RQ11: With hardware clearing a controller uses pulse and index to drop the request.
// RQ12: In debug mode all interrupt requests are ignored whatever the enables.
// RQ13: Causes: 2 illegal instruction, 3 breakpoint, 11 machine environment call.
// RQ14: Illegal instruction and environment call exceptions can never be masked.
// RQ15: Illegal or undefined encodings trap unless configured as custom instructions.
// RQ16: With the floating-point parameter 0 every single-precision instruction traps.
// RQ17: With the vendor extension parameter 0 every vendor extension instruction traps.
// RQ18: Handler entry saves the PC to exception PC and global enable to previous.
// RQ19: Vectored interrupts go to base plus four times index; others to base.
// RQ20: Return resumes at the saved PC and restores global enable from previous.
// RQ21: Handler entry clears the global enable.
// RQ22: The taken pulse comes in the same cycle as the trap redirect.
`ifndef CTL_DEFS_SVH
`define CTL_DEFS_SVH
`define CTL_OFS_STATUS 6'h00
`define CTL_OFS_ENABLE 6'h04
`define CTL_OFS_PENDING 6'h08
`define CTL_OFS_VECTOR 6'h0c
`define CTL_OFS_EPC 6'h10
`define CTL_OFS_CAUSE 6'h14
`define CTL_BIT_GIE 3
`define CTL_BIT_PGIE 7
`define CTL_LINE_MASK 32'hffff0888
`define CTL_LINE_EXT 5'h0b
`define CTL_LINE_TIMER 5'h07
`define CTL_LINE_SOFT 5'h03
`define CTL_LINE_CUSTOM_LO 16
`define CTL_LINE_CUSTOM_HI 31
`define CTL_VEC_BASE_MASK 32'hffffff00
`define CTL_VEC_MODE_BIT 0
`define CTL_CAUSE_ILLEGAL 32'h00000002
`define CTL_CAUSE_BREAK 32'h00000003
`define CTL_CAUSE_ECALL 32'h0000000b
`define CTL_RESP_OKAY 2'h0
`define CTL_RESP_SLVERR 2'h2
`define CTL_OP_LUI 7'h37
`define CTL_OP_AUIPC 7'h17
`define CTL_OP_JAL 7'h6f
`define CTL_OP_JALR 7'h67
`define CTL_OP_BRANCH 7'h63
`define CTL_OP_LOAD 7'h03
`define CTL_OP_STORE 7'h23
`define CTL_OP_IMM 7'h13
`define CTL_OP_REG 7'h33
`define CTL_OP_FENCE 7'h0f
`define CTL_OP_SYSTEM 7'h73
`define CTL_OP_FLW 7'h07
`define CTL_OP_FSW 7'h27
`define CTL_OP_FMADD 7'h43
`define CTL_OP_FMSUB 7'h47
`define CTL_OP_FNMSUB 7'h4b
`define CTL_OP_FNMADD 7'h4f
`define CTL_OP_FP 7'h53
`define CTL_OP_CUST0 7'h0b
`define CTL_OP_CUST1 7'h2b
`define CTL_OP_CUST2 7'h5b
`define CTL_OP_CUST3 7'h7b
`define CTL_INSN_ECALL 32'h00000073
`define CTL_INSN_EBREAK 32'h00100073
`define CTL_INSN_MRET 32'h30200073
`define CTL_INSN_WFI 32'h10500073
`endif

/* File: core/ctl_pkg.sv */
// Types shared by the trap and interrupt logic
package ctl_pkg;
  // Result of the interrupt priority search
  typedef struct packed {
    logic hit;
    logic [4:0] idx;
  } ctl_pick_type;
  // Decoded class of the instruction at the head of the pipe
  typedef struct packed {
    logic illegal;
    logic ebreak;
    logic ecall;
    logic mret;
  } ctl_dec_type;
endpackage

/* File: core/ctl_decode.sv */
// Instruction classifier: illegal encodings, breakpoint, environment call, return
`timescale 1ns/10ps
`default_nettype none
`include "ctl_defs.svh"
module ctl_decode #(
  parameter bit FPU_ENABLE = 1'b0,
  parameter bit VENDOR_EXT_ENABLE = 1'b0
) (
  // Instruction word
  input wire logic [31:0] instr,
  // Classification
  output var ctl_pkg::ctl_dec_type dec
);
  wire [6:0] op = instr[6:0];
  wire [2:0] f3 = instr[14:12];
  wire [6:0] f7 = instr[31:25];
  wire is_fp_op;
  wire is_vendor_op;
  wire is_csr;
  wire base_legal;

  // Single-precision and vendor extension opcode groups
  assign is_fp_op = (op == `CTL_OP_FLW) || (op == `CTL_OP_FSW) || (op == `CTL_OP_FMADD) ||
                    (op == `CTL_OP_FMSUB) || (op == `CTL_OP_FNMSUB) ||
                    (op == `CTL_OP_FNMADD) || (op == `CTL_OP_FP);
  assign is_vendor_op = (op == `CTL_OP_CUST0) || (op == `CTL_OP_CUST1) ||
                        (op == `CTL_OP_CUST2) || (op == `CTL_OP_CUST3);
  assign is_csr = (op == `CTL_OP_SYSTEM) && (f3 != 3'h0) && (f3 != 3'h4);

  // Base integer and multiply encodings that are defined
  assign base_legal =
    (op == `CTL_OP_LUI) || (op == `CTL_OP_AUIPC) || (op == `CTL_OP_JAL) ||
    ((op == `CTL_OP_JALR) && (f3 == 3'h0)) ||
    ((op == `CTL_OP_BRANCH) && (f3 != 3'h2) && (f3 != 3'h3)) ||
    ((op == `CTL_OP_LOAD) && (f3 != 3'h3) && (f3 != 3'h6) && (f3 != 3'h7)) ||
    ((op == `CTL_OP_STORE) && (f3 <= 3'h2)) ||
    ((op == `CTL_OP_IMM) && ((f3 == 3'h1) ? (f7 == 7'h00) :
      (f3 == 3'h5) ? ((f7 == 7'h00) || (f7 == 7'h20)) : 1'b1)) ||
    ((op == `CTL_OP_REG) && ((f7 == 7'h00) || (f7 == 7'h01) ||
      ((f7 == 7'h20) && ((f3 == 3'h0) || (f3 == 3'h5))))) ||
    ((op == `CTL_OP_FENCE) && (f3 <= 3'h1)) ||
    is_csr || (instr == `CTL_INSN_ECALL) || (instr == `CTL_INSN_EBREAK) ||
    (instr == `CTL_INSN_MRET) || (instr == `CTL_INSN_WFI);

  // Custom encodings are legal only when the build enables them
  assign dec.illegal = (instr[1:0] != 2'h3) ||
                       !(base_legal ||                          // [RQ15]
                         (is_fp_op && FPU_ENABLE) ||            // [RQ16]
                         (is_vendor_op && VENDOR_EXT_ENABLE));  // [RQ17]
  assign dec.ebreak = (instr == `CTL_INSN_EBREAK);
  assign dec.ecall = (instr == `CTL_INSN_ECALL);
  assign dec.mret = (instr == `CTL_INSN_MRET);
endmodule
`default_nettype wire

/* File: core/ctl_trap.sv */
// Trap and interrupt logic with its control registers on AXI4-Lite
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "ctl_defs.svh"
module ctl_trap #(
  parameter bit FPU_ENABLE = 1'b0,
  parameter bit VENDOR_EXT_ENABLE = 1'b0
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Interrupt request lines and debug state
  input wire logic [31:0] irq_lines,
  input wire logic debug_mode,
  // Instruction at the head of the pipe
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  input wire logic [31:0] instr_pc,
  // Interrupt acknowledge to the sources
  output logic irq_taken,
  output logic [4:0] taken_interrupt_index,
  // Fetch redirect
  output logic redirect_valid,
  output logic [31:0] redirect_pc,
  // AXI4-Lite write address and data
  input wire logic [5:0] s_awaddr,
  input wire logic [2:0] s_awprot,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  // AXI4-Lite write response
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // AXI4-Lite read
  input wire logic [5:0] s_araddr,
  input wire logic [2:0] s_arprot,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);
  // Architectural state
  logic gie;
  logic pgie;
  logic [31:0] line_enable;
  logic [31:0] vec_base;
  logic vec_mode;
  logic [31:0] epc;
  logic [31:0] cause;
  // Bus side state
  logic aw_have;
  logic w_have;
  logic [5:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // Priority search: later matches override, so the last hit is the winner
  function automatic ctl_pkg::ctl_pick_type pick(input logic [31:0] v);
    pick = '0;
    if (v[`CTL_LINE_TIMER]) begin
      pick = '{hit: 1'b1, idx: `CTL_LINE_TIMER};
    end
    if (v[`CTL_LINE_SOFT]) begin
      pick = '{hit: 1'b1, idx: `CTL_LINE_SOFT};
    end
    if (v[`CTL_LINE_EXT]) begin
      pick = '{hit: 1'b1, idx: `CTL_LINE_EXT};
    end
    for (int i = `CTL_LINE_CUSTOM_LO; i <= `CTL_LINE_CUSTOM_HI; i++) begin
      if (v[i]) begin
        pick = '{hit: 1'b1, idx: 5'(i)};
      end
    end
  endfunction

  // Byte lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        merge[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
  endfunction

  // Instruction classification
  ctl_pkg::ctl_dec_type dec;
  ctl_decode #(
    .FPU_ENABLE(FPU_ENABLE),
    .VENDOR_EXT_ENABLE(VENDOR_EXT_ENABLE)
  ) u_ctl_decode (
    .instr(instr_word),
    .dec(dec)
  );

  // Pending view and interrupt selection
  wire [31:0] pending = irq_lines & `CTL_LINE_MASK;             // [RQ1] [RQ3] [RQ6]
  wire [31:0] armed = pending & line_enable;
  wire ctl_pkg::ctl_pick_type winner = pick(armed);             // [RQ9]
  wire int_take = instr_valid && winner.hit && gie && !debug_mode;  // [RQ8] [RQ12]
  wire exc_take = instr_valid && !int_take &&
                  (dec.illegal || dec.ebreak || dec.ecall);     // [RQ14]
  wire trap_take = int_take || exc_take;
  wire ret_take = instr_valid && !int_take && dec.mret && !dec.illegal;

  // Cause and target of the trap being committed
  wire [31:0] next_cause = int_take ? {1'b1, 26'h0, winner.idx} :
                           dec.illegal ? `CTL_CAUSE_ILLEGAL :
                           dec.ebreak ? `CTL_CAUSE_BREAK : `CTL_CAUSE_ECALL;  // [RQ13]
  wire [31:0] vec_target = vec_base + {25'h0, winner.idx, 2'h0};
  wire [31:0] trap_target = (int_take && vec_mode) ? vec_target : vec_base;  // [RQ19]

  // Bus handshakes and address decode
  wire aw_fire = s_awvalid && s_awready;
  wire w_fire = s_wvalid && s_wready;
  wire ar_fire = s_arvalid && s_arready;
  wire do_write = aw_have && w_have && !s_bvalid;
  wire next_aw_have = aw_have ? !do_write : aw_fire;
  wire next_w_have = w_have ? !do_write : w_fire;
  wire next_bvalid = do_write || (s_bvalid && !s_bready);
  wire next_rvalid = ar_fire || (s_rvalid && !s_rready);
  wire wr_status = do_write && (aw_addr == `CTL_OFS_STATUS);
  wire wr_enable = do_write && (aw_addr == `CTL_OFS_ENABLE);
  wire wr_vector = do_write && (aw_addr == `CTL_OFS_VECTOR);
  wire wr_epc = do_write && (aw_addr == `CTL_OFS_EPC);
  wire wr_known = wr_status || wr_enable || wr_vector || wr_epc ||
                  (aw_addr == `CTL_OFS_PENDING) || (aw_addr == `CTL_OFS_CAUSE);
  wire [31:0] status_word = {24'h0, pgie, 3'h0, gie, 3'h0};
  wire [31:0] status_new = merge(status_word, w_data, w_strb);
  wire [31:0] vector_word = vec_base | {31'h0, vec_mode};
  wire [31:0] vector_new = merge(vector_word, w_data, w_strb);

  // Read address with the byte lane bits dropped, as on the write side
  wire [5:0] ar_word = {s_araddr[5:2], 2'h0};

  // Read data selection
  logic [31:0] rd_word;
  logic rd_known;
  always_comb begin
    rd_known = 1'b1;
    unique case (ar_word)
      `CTL_OFS_STATUS: rd_word = status_word;
      `CTL_OFS_ENABLE: rd_word = line_enable;
      `CTL_OFS_PENDING: rd_word = pending;
      `CTL_OFS_VECTOR: rd_word = vector_word;
      `CTL_OFS_EPC: rd_word = epc;
      `CTL_OFS_CAUSE: rd_word = cause;
      default: begin
        rd_word = 32'h0;
        rd_known = 1'b0;
      end
    endcase
  end

  // Global enable: trap entry clears it, return restores it, trap beats software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gie <= 1'b0;                                              // [RQ7]
      pgie <= 1'b0;
    end else if (trap_take) begin
      pgie <= gie;                                              // [RQ18]
      gie <= 1'b0;                                              // [RQ21]
    end else if (ret_take) begin
      gie <= pgie;                                              // [RQ20]
      pgie <= 1'b1;
    end else if (wr_status) begin
      gie <= status_new[`CTL_BIT_GIE];
      pgie <= status_new[`CTL_BIT_PGIE];
    end
  end

  // Per-line enables, only implemented lines can be set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_enable <= 32'h0;                                     // [RQ7]
    end else if (wr_enable) begin
      line_enable <= merge(line_enable, w_data, w_strb) & `CTL_LINE_MASK;  // [RQ6]
    end
  end

  // Vector base and mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      vec_base <= 32'h0;
      vec_mode <= 1'b0;
    end else if (wr_vector) begin
      vec_base <= vector_new & `CTL_VEC_BASE_MASK;
      vec_mode <= vector_new[`CTL_VEC_MODE_BIT];
    end
  end

  // Exception PC: trap entry beats a software write in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      epc <= 32'h0;
    end else if (trap_take) begin
      epc <= instr_pc;                                          // [RQ18]
    end else if (wr_epc) begin
      epc <= merge(epc, w_data, w_strb);
    end
  end

  // Cause of the last trap, read only for software
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cause <= 32'h0;
    end else if (trap_take) begin
      cause <= next_cause;                                      // [RQ13]
    end
  end

  // Commit: acknowledge pulse and redirect leave together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_taken <= 1'b0;
      taken_interrupt_index <= 5'h0;
      redirect_valid <= 1'b0;
      redirect_pc <= 32'h0;
    end else begin
      irq_taken <= int_take;                                    // [RQ4] [RQ22]
      taken_interrupt_index <= int_take ? winner.idx : 5'h0;    // [RQ5]
      redirect_valid <= trap_take || ret_take;                  // [RQ22]
      redirect_pc <= trap_take ? trap_target : (ret_take ? epc : 32'h0);  // [RQ20]
    end
  end

  // Write channel occupancy: each half is held until the write is done
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
    end else begin
      aw_have <= next_aw_have;
      w_have <= next_w_have;
    end
  end

  // Write readies stay low while a half is held or a response waits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_awready <= 1'b0;
      s_wready <= 1'b0;
    end else begin
      s_awready <= !next_aw_have && !next_bvalid;
      s_wready <= !next_w_have && !next_bvalid;
    end
  end

  // Write payload capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr <= 6'h0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end else begin
      if (aw_fire) begin
        aw_addr <= {s_awaddr[5:2], 2'h0};
      end
      if (w_fire) begin
        w_data <= s_wdata;
        w_strb <= s_wstrb;
      end
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_bvalid <= 1'b0;
      s_bresp <= `CTL_RESP_OKAY;
    end else begin
      s_bvalid <= next_bvalid;
      if (do_write) begin
        s_bresp <= wr_known ? `CTL_RESP_OKAY : `CTL_RESP_SLVERR;
      end
    end
  end

  // Read handshake: one read at a time, address refused while data waits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
    end else begin
      s_arready <= !next_rvalid;
      s_rvalid <= next_rvalid;
    end
  end

  // Read data and response, held until the master takes them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rdata <= 32'h0;
      s_rresp <= `CTL_RESP_OKAY;
    end else if (ar_fire) begin
      s_rdata <= rd_word;
      s_rresp <= rd_known ? `CTL_RESP_OKAY : `CTL_RESP_SLVERR;
    end
  end
endmodule
`default_nettype wire

/* File: verif/ctl_trap_props.sv */
// Assertions on the trap logic ports
`timescale 1ns/10ps
`default_nettype none
`include "ctl_defs.svh"
module ctl_trap_props (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Requests and instruction
  input wire logic [31:0] irq_lines,
  input wire logic debug_mode,
  input wire logic instr_valid,
  input wire logic [31:0] instr_word,
  // Acknowledge and redirect
  input wire logic irq_taken,
  input wire logic [4:0] taken_interrupt_index,
  input wire logic redirect_valid
);
  logic [31:0] prev_lines;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Line levels seen at the deciding edge
  always_ff @(posedge aclk) begin
    prev_lines <= irq_lines;
  end
  // One pulse, then quiet for the next two cycles
  sequence s_pulse;
    irq_taken ##1 !irq_taken ##1 !irq_taken;
  endsequence
  sequence s_quiet;
    !irq_taken && !redirect_valid;
  endsequence
  AST_PULSE: assert property (irq_taken |-> s_pulse)
    else $error("taken pulse too long or repeated");
  AST_IDX: assert property (!irq_taken |-> taken_interrupt_index == 5'h00)
    else $error("index shown without pulse");
  AST_MAP: assert property (irq_taken |-> taken_interrupt_index >= 5'h10 ||
    taken_interrupt_index inside {5'h03, 5'h07, 5'h0b})
    else $error("reserved line taken");
  AST_LEVEL: assert property (irq_taken |-> prev_lines[taken_interrupt_index])
    else $error("taken line was low");
  AST_DEBUG: assert property (debug_mode |=> !irq_taken)
    else $error("interrupt taken in debug mode");
  AST_PAIR: assert property (irq_taken |-> redirect_valid)
    else $error("taken pulse without redirect");
  AST_QUIET: assert property (!instr_valid |=> s_quiet)
    else $error("trap without instruction");
  AST_ECALL: assert property (instr_valid && (instr_word == `CTL_INSN_ECALL ||
    instr_word == `CTL_INSN_EBREAK) |=> redirect_valid)
    else $error("call or break not trapped");
endmodule
bind ctl_trap ctl_trap_props u_ctl_trap_props (.aclk(aclk), .aresetn(aresetn),
  .irq_lines(irq_lines), .debug_mode(debug_mode), .instr_valid(instr_valid),
  .instr_word(instr_word), .irq_taken(irq_taken),
  .taken_interrupt_index(taken_interrupt_index), .redirect_valid(redirect_valid));
`default_nettype wire

/* File: verif/ctl_irq_src.sv */
// Interrupt source model with software and hardware clearing
`timescale 1ns/10ps
`default_nettype none
`include "ctl_defs.svh"
module ctl_irq_src (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bench control
  input wire logic [31:0] raise,
  input wire logic [31:0] drop,
  input wire logic hw_clear,
  // Acknowledge from the core
  input wire logic irq_taken,
  input wire logic [4:0] taken_interrupt_index,
  // Request lines
  output logic [31:0] irq_lines
);
  logic [31:0] ack_clear;
  logic [31:0] next_lines;
  // Controller drops the acknowledged line, index read only with the pulse
  assign ack_clear = (hw_clear && irq_taken) ? 32'h00000001 << taken_interrupt_index
    : 32'h00000000;
  // Reserved lines stay low; a source holds its line until told to drop it
  assign next_lines = (irq_lines | raise) & ~drop & ~ack_clear & `CTL_LINE_MASK;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_lines <= 32'h00000000;
    end else begin
      irq_lines <= next_lines;
    end
  end
endmodule
`default_nettype wire

/* File: verif/test_ctl_trap.sv */
// Self-checking bench for the trap and interrupt logic
`timescale 1ns/10ps
`default_nettype none
module test_ctl_trap;
  logic aclk = 1'b0, aresetn = 1'b0, debug_mode = 1'b0, hw_clear = 1'b1;
  logic instr_valid = 1'b0;
  logic [31:0] instr_word = 32'h00000013, instr_pc = 32'h00000000;
  logic [31:0] raise = 32'h00000000, drop = 32'h00000000, irq_lines;
  logic [5:0] s_awaddr = 6'h00, s_araddr = 6'h00;
  logic [31:0] s_wdata = 32'h00000000, s_rdata, redirect_pc;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
  logic s_arvalid = 1'b0, s_rready = 1'b0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, irq_taken, redirect_valid;
  logic [1:0] s_bresp, s_rresp;
  logic [4:0] taken_interrupt_index;
  int n_mismatch = 0, checks = 0;
  // Clock of 20 ns
  always #10 aclk = ~aclk;
  ctl_trap u_ctl_trap (.aclk(aclk), .aresetn(aresetn), .irq_lines(irq_lines),
    .debug_mode(debug_mode), .instr_valid(instr_valid), .instr_word(instr_word),
    .instr_pc(instr_pc), .irq_taken(irq_taken), .taken_interrupt_index(taken_interrupt_index),
    .redirect_valid(redirect_valid), .redirect_pc(redirect_pc), .s_awaddr(s_awaddr),
    .s_awprot(3'h0), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
    .s_wstrb(4'hf), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arprot(3'h0),
    .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
    .s_rvalid(s_rvalid), .s_rready(s_rready));
  ctl_irq_src u_ctl_irq_src (.aclk(aclk), .aresetn(aresetn), .raise(raise), .drop(drop),
    .hw_clear(hw_clear), .irq_taken(irq_taken),
    .taken_interrupt_index(taken_interrupt_index), .irq_lines(irq_lines));
  // Verdict and end of run
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks = checks + 1;
    if (g !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Register write, address and data offered together
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] e);
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
    end while (!s_bvalid);
    s_bready <= 1'b0;
    chk({30'h0, s_bresp}, {30'h0, e});
  endtask
  // Register read with expected data and response
  task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
    end while (!s_rvalid);
    s_rready <= 1'b0;
    chk(s_rdata, e);
    chk({30'h0, s_rresp}, {30'h0, er});
  endtask
  // One instruction, then the pulse, index and redirect one cycle later
  task automatic op(input logic [31:0] w, input logic [31:0] pc, input logic [5:0] t,
    input logic r, input logic [31:0] p);
    @(posedge aclk);
    instr_valid <= 1'b1;
    instr_word <= w;
    instr_pc <= pc;
    @(posedge aclk);
    instr_valid <= 1'b0;
    #1;
    chk({26'h0, irq_taken, taken_interrupt_index}, {26'h0, t});
    chk({31'h0, redirect_valid}, {31'h0, r});
    chk(redirect_pc, p);
  endtask
  // Raise or drop source lines for one cycle
  task automatic src(input logic [31:0] r, input logic [31:0] d);
    @(posedge aclk);
    raise <= r;
    drop <= d;
    @(posedge aclk);
    raise <= 32'h0;
    drop <= 32'h0;
  endtask
  task automatic t_reset;
    rd(6'h04, 32'h0, 2'h0);
    rd(6'h00, 32'h0, 2'h0);
    rd(6'h18, 32'h0, 2'h2);
    $display("reset test done");
  endtask
  task automatic t_mask;
    wr(6'h00, 32'h8, 2'h0);
    src(32'h800, 32'h0);
    op(32'h13, 32'h40, 6'h00, 1'b0, 32'h0);
    wr(6'h04, 32'hffffffff, 2'h0);
    wr(6'h00, 32'h0, 2'h0);
    op(32'h13, 32'h44, 6'h00, 1'b0, 32'h0);
    $display("mask test done");
  endtask
  task automatic t_prio;
    logic [4:0] k;
    logic [31:0] pc;
    wr(6'h0c, 32'h101, 2'h0);
    src(32'hffffffff, 32'h0);
    rd(6'h08, 32'hffff0888, 2'h0);
    for (int i = 0; i < 19; i++) begin
      k = (i < 16) ? 5'(31 - i) : (i == 16) ? 5'h0b : (i == 17) ? 5'h03 : 5'h07;
      pc = 32'h200 + 32'(i * 4);
      wr(6'h00, 32'h8, 2'h0);
      op(32'h13, pc, {1'b1, k}, 1'b1, 32'h100 + {25'h0, k, 2'b00});
      rd(6'h10, pc, 2'h0);
      rd(6'h14, {1'b1, 26'h0, k}, 2'h0);
      rd(6'h00, 32'h80, 2'h0);
    end
    rd(6'h08, 32'h0, 2'h0);
    $display("priority test done");
  endtask
  task automatic t_mret;
    op(32'h30200073, 32'h300, 6'h00, 1'b1, 32'h248);
    rd(6'h00, 32'h88, 2'h0);
    $display("return test done");
  endtask
  task automatic t_debug;
    @(posedge aclk);
    hw_clear <= 1'b0;
    debug_mode <= 1'b1;
    src(32'h8, 32'h0);
    op(32'h13, 32'h400, 6'h00, 1'b0, 32'h0);
    wr(6'h0c, 32'h100, 2'h0);
    debug_mode <= 1'b0;
    op(32'h13, 32'h404, 6'h23, 1'b1, 32'h100);
    rd(6'h08, 32'h8, 2'h0);
    src(32'h0, 32'h8);
    rd(6'h08, 32'h0, 2'h0);
    $display("debug test done");
  endtask
  task automatic t_exc;
    logic [31:0] wd [5] = '{32'h0, 32'h7, 32'hb, 32'h00100073, 32'h73};
    logic [31:0] cs [5] = '{32'h2, 32'h2, 32'h2, 32'h3, 32'hb};
    for (int i = 0; i < 5; i++) begin
      op(wd[i], 32'h500, 6'h00, 1'b1, 32'h100);
      rd(6'h14, cs[i], 2'h0);
      rd(6'h10, 32'h500, 2'h0);
    end
    op(32'h13, 32'h504, 6'h00, 1'b0, 32'h0);
    $display("exception test done");
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_mask();
    t_prio();
    t_mret();
    t_debug();
    t_exc();
    summarize();
  end
  // Watchdog
  initial begin
    #200000;
    n_mismatch = n_mismatch + 1;
    summarize();
  end
endmodule
`default_nettype wire
